// File: cdd_pkg.sv
// Constants for the dual-bank clock divider and delay block
package cdd_pkg;
    // Register byte offsets and indices
    localparam logic [4:0]  REG_IN_DIV     = 5'h00;
    localparam logic [4:0]  REG_OUT_DIV    = 5'h04;
    localparam logic [4:0]  REG_LARGE      = 5'h08;
    localparam logic [4:0]  REG_FINE       = 5'h0C;
    localparam logic [4:0]  REG_SYNC       = 5'h10;
    localparam logic [4:0]  REG_STATUS     = 5'h14;
    localparam logic [2:0]  NUM_CFG        = 3'h5;
    localparam logic [2:0]  STATUS_IDX     = 3'h5;
    // Field positions
    localparam int          IND_EN_BIT     = 3;
    localparam int          IND_BANK_STEP  = 4;
    localparam int          OD_GROUP_STEP  = 4;
    localparam int          OD_TYPE_LSB    = 12;
    localparam int          LG_DDLY_LSB    = 16;
    localparam int          LG_HS_BIT      = 26;
    localparam int          FN_EN_BIT      = 5;
    localparam int          SY_EXCL_LSB    = 1;
    // Reset values: dividers bypassed, coarse delay 5, LVDS, nothing excluded
    localparam logic [31:0] CFG_RST [5]    = '{32'h0000_0000, 32'h0000_0111,
                                               32'h0005_0001, 32'h0000_0000,
                                               32'h0000_0000};
    // Serial word: register index in the low bits, data above
    localparam int          SER_W          = 32;
    localparam int          SER_IDX_W      = 3;
    // Divider and delay limits
    localparam int          IN_MIN         = 2;
    localparam int          IN_MAX         = 8;
    localparam int          SMALL_MAX      = 8;
    localparam int          LARGE_MAX      = 1045;
    localparam int          EXT_MIN        = 26;
    localparam int          DDLY_MIN       = 5;
    localparam int          DDLY_NORM_MAX  = 12;
    localparam int          DDLY_EXT_MIN   = 13;
    localparam int          DDLY_MAX       = 522;
    localparam int          REL_BASE_HALF  = 9;
    localparam int          DIV_GT1_HALF   = 2;
    localparam int          FINE_STEP_PS   = 25;
    localparam int          FINE_OFS_PS    = 500;
    localparam int          FINE_CODE_MAX  = 19;
    // Strap decode ratios
    localparam int          STRAP_LO       = 1;
    localparam int          STRAP_HI       = 2;
    localparam int          STRAP_G4_LO_L  = 8;
    localparam int          STRAP_G4_LO_H  = 4;
    localparam int          STRAP_G4_HI    = 16;
    localparam logic [1:0]  TYPE_LVDS      = 2'h0;
endpackage

// File: cdd_top.sv
// Dual-bank clock divider with coarse and fine delay, serial and strap configuration
// Operation
// R1: Bank A clock feeds outputs 0-7, bank B clock feeds outputs 8-13.
// R2: Each bank has a shared input divider 2 to 8, enabled or bypassed; the 3-bit ratio field reaches 7 at most.
// R3: Outputs 0-3, 4-7, 8-11 each use a small divider of ratio 1 to 8.
// R4: Outputs 12-13 use a large divider of ratio 1 to 1045.
// R5: Large ratio of 26 or more selects extended delay mode.
// R6: Fine delay code in 25 ps steps to 475 ps, plus 500 ps when enabled.
// R7: Changing fine delay may glitch the affected outputs.
// R8: Coarse delay spans 4.5-12 cycles normally, 12.5-522 in extended mode.
// R9: Half-step bit trims coarse delay by half a distribution period.
// R10: Coarse delay equals count 5 to 522, minus half when half-step set.
// R11: New coarse count applies only at a sync with group four not excluded.
// R12: Outputs 12-13 lag outputs 8-11 by delay minus 4.5, one more if ratio above one.
// R13: Sync aligns all active non-excluded outputs to a common rising edge.
// R14: After reset all outputs run, dividers bypassed, LVDS type.
// R15: Floating select means serial configuration; driven select means strap pins.
// R16: Strap mode decodes serial pins with separate tables for select high and low.
// R17: Serial data shifts on serial clock rise; latch rise writes addressed register.
// R18: Sync holds affected outputs low; release restarts them with their delays.
// R19: Groups with sync exclude set keep running through any sync.
// R20: Half-step changes take effect at once, without a sync.
// R21: Every divider gives fifty percent duty for odd and even ratios.
// R22: New divider ratios load at terminal count or at sync only; the input dividers apply a new cfg_r[0] ratio at once.
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module cdd_top
    import cdd_pkg::*;
#(
    parameter int DIV_W = 12
) (
    input  wire logic        CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [4:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        BANK_A_CLK_I,
    input  wire logic        BANK_B_CLK_I,
    input  wire logic        SYNC_I,
    input  wire logic        PIN_CTRL_FLOAT_I,
    input  wire logic        PIN_CTRL_HIGH_I,
    input  wire logic        SER_CLK_I,
    input  wire logic        SER_DATA_I,
    input  wire logic        SER_LATCH_I,
    output logic      [13:0] CLK_OUT_O,
    output logic             EXT_MODE_O,
    output logic      [9:0]  FINE_DELAY_PS_O,
    output logic      [1:0]  OUT_TYPE_O
);
    import cdd_pkg::*;

    if (DIV_W < 12) begin : g_chk
        $error("DIV_W must hold twice the largest ratio");
    end

    typedef logic [DIV_W-1:0] cdd_div_t;

    function automatic cdd_div_t clampr(input cdd_div_t v, input int lo, input int hi);
        clampr = v;
        if (v < cdd_div_t'(lo)) clampr = cdd_div_t'(lo);
        if (v > cdd_div_t'(hi)) clampr = cdd_div_t'(hi);
    endfunction

    function automatic logic [9:0] eff_ddly(input logic [9:0] d, input cdd_div_t ratio);
        if (ratio >= cdd_div_t'(EXT_MIN)) begin
            eff_ddly = 10'(clampr(cdd_div_t'(d), DDLY_EXT_MIN, DDLY_MAX)); // R8
        end else begin
            eff_ddly = 10'(clampr(cdd_div_t'(d), DDLY_MIN, DDLY_NORM_MAX)); // R8
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    logic [31:0]    cfg_r [5];
    logic           ack_r;
    logic [31:0]    dat_r;
    logic           sclk_q_r;
    logic           slat_q_r;
    logic [31:0]    shift_r;
    logic [1:0]     clk_q_r;
    logic [2:0]     icnt_r [2];
    cdd_div_t       cnt_r [4];
    cdd_div_t       ract_r [4];
    cdd_div_t       wait_r [4];
    logic [3:0]     out_r;
    logic [9:0]     ddly_act_r;
    logic           hs_q_r;
    logic           ext_r;
    logic [9:0]     fine_r;
    logic [1:0]     type_r;

    // Bus decode
    wire            req      = CYC_I & STB_I;
    wire [2:0]      wb_idx   = ADR_I[4:2];
    wire            wb_ok    = (ADR_I[1:0] == 2'h0);
    wire            wb_wr    = req & WE_I & ack_r & wb_ok & (wb_idx < NUM_CFG);
    wire [31:0]     status   = {16'h0, ext_r, PIN_CTRL_FLOAT_I, out_r, ddly_act_r};
    wire [31:0]     rd_mux   = !wb_ok ? 32'h0 :
                               (wb_idx < NUM_CFG) ? cfg_r[wb_idx] :
                               (wb_idx == STATUS_IDX) ? status : 32'h0;

    // Serial port and mode select
    wire            ser_mode = PIN_CTRL_FLOAT_I; // R15
    wire            ser_shift = ser_mode & SER_CLK_I & ~sclk_q_r; // R17
    wire            ser_wr   = ser_mode & SER_LATCH_I & ~slat_q_r; // R17
    wire [2:0]      ser_idx  = shift_r[SER_IDX_W-1:0];

    // Strap decode, separate tables for select high and low
    wire            strap_g1 = PIN_CTRL_HIGH_I ? SER_DATA_I : SER_CLK_I; // R16
    wire            strap_g2 = PIN_CTRL_HIGH_I ? SER_CLK_I : SER_LATCH_I; // R16
    wire [3:0]      strap_bit = {SER_LATCH_I, strap_g2, strap_g1, SER_DATA_I};
    cdd_div_t       ratio_new [4];
    cdd_div_t       ratio_in [2];
    logic [1:0]     in_en;
    logic [1:0]     tick;
    for (genvar g = 0; g < 3; g++) begin : g_small
        assign ratio_new[g] = ser_mode ?
            clampr(cdd_div_t'(cfg_r[1][OD_GROUP_STEP*g +: 4]), 1, SMALL_MAX) : // R3
            cdd_div_t'(strap_bit[g] ? STRAP_HI : STRAP_LO); // R16
    end
    assign ratio_new[3] = ser_mode ? clampr(cdd_div_t'(cfg_r[2][10:0]), 1, LARGE_MAX) : // R4
                          !strap_bit[3] ? cdd_div_t'(PIN_CTRL_HIGH_I ? STRAP_G4_LO_H
                                                                     : STRAP_G4_LO_L) :
                          cdd_div_t'(STRAP_G4_HI); // R16

    // Input dividers count half periods so odd ratios keep 50% duty
    wire [1:0]      in_edge  = {BANK_B_CLK_I, BANK_A_CLK_I} ^ clk_q_r;
    for (genvar b = 0; b < 2; b++) begin : g_in
        assign ratio_in[b] = clampr(cdd_div_t'(cfg_r[0][IND_BANK_STEP*b +: 3]), IN_MIN, IN_MAX);
        assign in_en[b]    = ser_mode & cfg_r[0][IND_BANK_STEP*b + IND_EN_BIT]; // R2
        assign tick[b]     = in_edge[b] &
                             (~in_en[b] | (cdd_div_t'(icnt_r[b]) == ratio_in[b] - 1'b1)); // R2
    end
    wire [3:0]      gtick    = {tick[1], tick[1], tick[0], tick[0]}; // R1

    // Sync and delay selection
    wire [3:0]      excl     = cfg_r[4][SY_EXCL_LSB +: 4];
    wire            sync_req = SYNC_I | cfg_r[4][0];
    wire [3:0]      held     = {4{sync_req}} & ~excl; // R19
    wire            hs_cfg   = cfg_r[2][LG_HS_BIT]; // R9
    wire            hs_chg   = hs_cfg != hs_q_r;
    wire [9:0]      ddly_nxt = eff_ddly(cfg_r[2][LG_DDLY_LSB +: 10], ratio_new[3]);
    wire cdd_div_t  rel_nxt  = cdd_div_t'({ddly_nxt, 1'b0}) - cdd_div_t'(hs_cfg) // R10
                               - cdd_div_t'(REL_BASE_HALF)
                               + ((ratio_new[3] > cdd_div_t'(1)) ? cdd_div_t'(DIV_GT1_HALF)
                                                                 : cdd_div_t'(0)); // R12
    wire [4:0]      fine_code = (cfg_r[3][4:0] > 5'(FINE_CODE_MAX)) ? 5'(FINE_CODE_MAX)
                                                                    : cfg_r[3][4:0];
    // Fine delay is not glitch-protected; software expects glitches while changing it
    wire [9:0]      fine_nxt = cfg_r[3][FN_EN_BIT] ?
                               10'(FINE_OFS_PS) + 10'(fine_code) * 10'(FINE_STEP_PS) : 10'h0; // R6 R7

    assign ACK_O           = ack_r;
    assign DAT_O           = dat_r;
    assign CLK_OUT_O       = {{2{out_r[3]}}, {4{out_r[2]}}, {4{out_r[1]}}, {4{out_r[0]}}}; // R1
    assign EXT_MODE_O      = ext_r;
    assign FINE_DELAY_PS_O = fine_r;
    assign OUT_TYPE_O      = type_r;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= req & ~ack_r;
            dat_r <= (req & ~ack_r) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < 5; i++) begin
                cfg_r[i] <= CFG_RST[i]; // R14
            end
            sclk_q_r <= 1'b0;
            slat_q_r <= 1'b0;
            shift_r  <= 32'h0;
        end else begin
            sclk_q_r <= SER_CLK_I;
            slat_q_r <= SER_LATCH_I;
            if (ser_shift) begin
                shift_r <= {shift_r[SER_W-2:0], SER_DATA_I}; // R17
            end
            if (ser_wr && ser_idx < NUM_CFG) begin
                cfg_r[ser_idx] <= {3'h0, shift_r[SER_W-1:SER_IDX_W]}; // R17
            end
            if (wb_wr) begin
                cfg_r[wb_idx] <= merge(cfg_r[wb_idx], DAT_I, SEL_I);
            end
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            clk_q_r   <= 2'h0;
            icnt_r[0] <= 3'h0;
            icnt_r[1] <= 3'h0;
        end else begin
            clk_q_r <= {BANK_B_CLK_I, BANK_A_CLK_I};
            for (int b = 0; b < 2; b++) begin
                if (!in_en[b] || tick[b]) begin
                    icnt_r[b] <= 3'h0;
                end else if (in_edge[b]) begin
                    icnt_r[b] <= icnt_r[b] + 3'h1; // R2
                end
            end
        end
    end

    // Output dividers: toggle every ratio half periods
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            for (int g = 0; g < 4; g++) begin
                cnt_r[g]  <= '0;
                ract_r[g] <= cdd_div_t'(1); // R14
                wait_r[g] <= '0;
            end
            out_r      <= 4'h0;
            ddly_act_r <= 10'(DDLY_MIN);
            hs_q_r     <= 1'b0;
        end else begin
            hs_q_r <= hs_cfg;
            if (held[3]) begin
                ddly_act_r <= ddly_nxt; // R11
            end
            for (int g = 0; g < 4; g++) begin
                if (held[g]) begin
                    out_r[g]  <= 1'b0; // R18
                    cnt_r[g]  <= ratio_new[g] - 1'b1; // R13
                    ract_r[g] <= ratio_new[g]; // R22
                    wait_r[g] <= (g == 3) ? rel_nxt : '0; // R12
                end else if (g == 3 && hs_chg) begin
                    wait_r[g] <= hs_cfg ? cdd_div_t'({ract_r[g], 1'b0} - 1'b1)
                                        : cdd_div_t'(1); // R20
                end else if (gtick[g]) begin
                    if (wait_r[g] != '0) begin
                        wait_r[g] <= wait_r[g] - 1'b1;
                    end else if (cnt_r[g] >= ract_r[g] - 1'b1) begin
                        cnt_r[g]  <= '0;
                        out_r[g]  <= ~out_r[g]; // R21
                        ract_r[g] <= ratio_new[g]; // R22
                    end else begin
                        cnt_r[g] <= cnt_r[g] + 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ext_r  <= 1'b0;
            fine_r <= 10'h0;
            type_r <= TYPE_LVDS; // R14
        end else begin
            ext_r  <= ratio_new[3] >= cdd_div_t'(EXT_MIN); // R5
            fine_r <= fine_nxt; // R6
            type_r <= ser_mode ? cfg_r[1][OD_TYPE_LSB +: 2] : TYPE_LVDS;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    held_low_a: assert property (held != 4'h0 |=> (out_r & $past(held)) == 4'h0) // R18
        else $error("held group output not low");
    excl_keep_a: assert property (sync_req && excl[0] && !gtick[0] |=> $stable(out_r[0])) // R19
        else $error("excluded group disturbed by sync");
    ext_mode_a: assert property (ratio_new[3] >= cdd_div_t'(EXT_MIN) ##1 $stable(ratio_new[3])
                                 |-> EXT_MODE_O) // R5
        else $error("extended mode flag missing");
    fine_range_a: assert property (FINE_DELAY_PS_O <= 10'h3CF &&
                                   (FINE_DELAY_PS_O == 10'h0 || FINE_DELAY_PS_O >= 10'h1F4)) // R6
        else $error("fine delay out of range");
    ddly_sync_a: assert property (!$stable(ddly_act_r) |-> $past(held[3])) // R11
        else $error("coarse delay changed without sync");
    ratio_load_a: assert property (!$stable(ract_r[0]) |-> $past(held[0]) ||
                                   $past(gtick[0] && cnt_r[0] >= ract_r[0] - 1'b1)) // R22
        else $error("ratio loaded mid period");
    small_range_a: assert property (ract_r[2] >= cdd_div_t'(1) &&
                                    ract_r[2] <= cdd_div_t'(SMALL_MAX)) // R3
        else $error("small divider ratio out of range");
    delay_wait_a: assert property (wait_r[3] != '0 && !held[3] |=> $stable(out_r[3])) // R12
        else $error("group four moved during delay");
    hs_now_a: assert property (hs_chg && !held[3] |=> wait_r[3] != '0) // R20
        else $error("half step not applied at once");
    duty_toggle_a: assert property (gtick[1] && !held[1] && cnt_r[1] >= ract_r[1] - 1'b1
                                    |=> out_r[1] != $past(out_r[1])) // R21
        else $error("divider missed its toggle");
    ser_write_a: assert property (ser_wr && ser_idx == 3'h1 && !(wb_wr && wb_idx == 3'h1)
                                  |=> cfg_r[1] == {3'h0, $past(shift_r[31:3])}) // R17
        else $error("serial word not written");
    bus_ack_a: assert property (req && !ack_r |=> ACK_O ##1 !ACK_O)
        else $error("bus answer not a single cycle");

    sync_rel_c: cover property (held[3] ##1 !held[3] ##[1:64] $rose(out_r[3]));
    hs_chg_c: cover property (hs_chg && !held[3]);
    ext_c: cover property ($rose(EXT_MODE_O));
    ser_c: cover property (ser_wr && ser_idx < NUM_CFG);
endmodule

// File: cdd_ser_host.sv
// Host model driving the three-wire serial configuration port and the strap levels
`timescale 1ns/1ps
module cdd_ser_host (
    input  wire logic clk_i,
    output logic      ser_clk_o,
    output logic      ser_data_o,
    output logic      ser_latch_o
);
    initial begin
        ser_clk_o   = 1'b0;
        ser_data_o  = 1'b0;
        ser_latch_o = 1'b0;
    end

    // Levels stand three cycles, two more than the port needs, MSB first
    task automatic send(input logic [31:0] word);
        for (int i = 31; i >= 0; i--) begin
            @(posedge clk_i);
            ser_data_o <= word[i];
            repeat (3) @(posedge clk_i);
            ser_clk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            ser_clk_o <= 1'b0;
        end
        repeat (3) @(posedge clk_i);
        ser_latch_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        ser_latch_o <= 1'b0;
        ser_data_o  <= 1'b0;
    endtask

    // Static strap levels once the select pin is driven
    task automatic strap(input logic d, input logic c, input logic l);
        @(posedge clk_i);
        ser_data_o  <= d;
        ser_clk_o   <= c;
        ser_latch_o <= l;
    endtask
endmodule

// File: cdd_top_tb_top.sv
// Self-checking bench for the dual-bank clock divider and delay block
`timescale 1ns/1ps
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin mismatches++; \
    $display("[ERR] %0t mismatch: got %0h expected %0h", $time, (act), (exp)); end end
module cdd_top_tb_top;
    import cdd_pkg::*;
    typedef struct {
        logic        we;
        logic [4:0]  adr;
        logic [31:0] wdat;
        logic [31:0] rdat;
        logic        ext;
        logic [9:0]  fine;
    } cdd_row_s;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic        bank_a = 1'b0, bank_b = 1'b0, sync = 1'b0, ser_mode = 1'b1, sel_high = 1'b0;
    logic [1:0]  phase = 2'h0;
    logic [31:0] rdat;
    logic        ack, ser_clk, ser_data, ser_latch, ext_mode;
    logic [13:0] clk_out;
    logic [9:0]  fine_ps;
    logic [1:0]  out_type;
    int          mismatches = 0;
    int          num_checks = 0;
    int          bits [4] = '{0, 4, 8, 12};
    int          rat  [4] = '{2, 3, 5, 3};
    cdd_row_s    rows [16] = '{
        '{1'b0, REG_IN_DIV, 32'h0, 32'h0000_0000, 1'b0, 10'h000},
        '{1'b0, REG_OUT_DIV, 32'h0, 32'h0000_0111, 1'b0, 10'h000},
        '{1'b0, REG_LARGE, 32'h0, 32'h0005_0001, 1'b0, 10'h000},
        '{1'b0, REG_FINE, 32'h0, 32'h0000_0000, 1'b0, 10'h000},
        '{1'b0, REG_SYNC, 32'h0, 32'h0000_0000, 1'b0, 10'h000},
        '{1'b0, 5'h02, 32'h0, 32'h0000_0000, 1'b0, 10'h000},
        '{1'b1, REG_LARGE, 32'h0005_001A, 32'h0, 1'b1, 10'h000},
        '{1'b1, REG_LARGE, 32'h0005_0019, 32'h0, 1'b0, 10'h000},
        '{1'b1, REG_LARGE, 32'h0005_0415, 32'h0, 1'b1, 10'h000},
        '{1'b0, REG_LARGE, 32'h0, 32'h0005_0415, 1'b1, 10'h000},
        '{1'b1, REG_FINE, 32'h0000_0020, 32'h0, 1'b1, 10'h1F4},
        '{1'b1, REG_FINE, 32'h0000_0033, 32'h0, 1'b1, 10'h3CF},
        '{1'b1, REG_FINE, 32'h0000_003F, 32'h0, 1'b1, 10'h3CF},
        '{1'b1, REG_FINE, 32'h0000_0013, 32'h0, 1'b1, 10'h000},
        '{1'b1, 5'h18, 32'hFFFF_FFFF, 32'h0, 1'b1, 10'h000},
        '{1'b0, 5'h18, 32'h0, 32'h0000_0000, 1'b1, 10'h000}};

    always #2 clk = ~clk;

    // Bank clocks change level every second cycle
    always @(posedge clk) begin
        phase  <= phase + 2'h1;
        bank_a <= phase[1];
        bank_b <= phase[1];
    end

    cdd_ser_host host (.clk_i(clk), .ser_clk_o(ser_clk), .ser_data_o(ser_data),
                       .ser_latch_o(ser_latch));

    cdd_top #(.DIV_W(12)) dut (
        .CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .BANK_A_CLK_I(bank_a),
        .BANK_B_CLK_I(bank_b), .SYNC_I(sync), .PIN_CTRL_FLOAT_I(ser_mode),
        .PIN_CTRL_HIGH_I(sel_high), .SER_CLK_I(ser_clk), .SER_DATA_I(ser_data),
        .SER_LATCH_I(ser_latch), .CLK_OUT_O(clk_out), .EXT_MODE_O(ext_mode),
        .FINE_DELAY_PS_O(fine_ps), .OUT_TYPE_O(out_type));

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Request stands until ack is sampled high at a rising edge; only the watchdog ends a wait
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hF;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    // Counts falling clock edges until the output bit reaches the level
    task automatic wait_lvl(input int b, input logic v, output int n);
        n = 0;
        while (clk_out[b] !== v && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000) begin
            mismatches++;
            $display("[ERR] %0t output %0d stuck", $time, b);
            give_verdict();
        end
    endtask

    task automatic per(input int b, output int hi, output int lo);
        int n;
        @(negedge clk);
        wait_lvl(b, 1'b0, n);
        wait_lvl(b, 1'b1, n);
        wait_lvl(b, 1'b0, hi);
        wait_lvl(b, 1'b1, lo);
    endtask

    initial begin
        #100000;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end

    initial begin
        logic [31:0] q;
        logic [31:0] lg [2];
        int          dl [2];
        int          hi, lo, n;
        lg = '{32'h0005_0003, 32'h0407_0003};
        dl = '{6, 12};
        repeat (16) @(posedge clk);
        @(negedge clk);
        `CHK(clk_out, 14'h0000)
        @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        foreach (bits[i]) begin
            per(bits[i], hi, lo);
            `CHK(hi, 2)
            `CHK(lo, 2)
        end
        $display("test reset_defaults done");
        foreach (rows[i]) begin
            wb(rows[i].we, rows[i].adr, rows[i].wdat, q);
            if (!rows[i].we) `CHK(q, rows[i].rdat)
            repeat (3) @(negedge clk);
            `CHK(ext_mode, rows[i].ext)
            `CHK(fine_ps, rows[i].fine)
        end
        $display("test register_table done");
        host.send({29'h0000532, 3'h1});
        repeat (4) @(posedge clk);
        wb(1'b0, REG_OUT_DIV, 32'h0, q);
        `CHK(q, 32'h0000_0532)
        wb(1'b1, REG_LARGE, lg[0], q);
        repeat (60) @(posedge clk);
        foreach (bits[i]) begin
            per(bits[i], hi, lo);
            `CHK(hi, 2 * rat[i])
            `CHK(lo, 2 * rat[i])
        end
        wb(1'b1, REG_IN_DIV, 32'h0000_000A, q);
        repeat (60) @(posedge clk);
        per(0, hi, lo);
        `CHK(hi, 8)
        per(8, hi, lo);
        `CHK(hi, 10)
        wb(1'b1, REG_IN_DIV, 32'h0000_0000, q);
        $display("test dividers done");
        wb(1'b1, REG_SYNC, 32'h0000_0002, q);
        foreach (lg[i]) begin
            wb(1'b1, REG_LARGE, lg[i], q);
            sync <= 1'b1;
            repeat (30) @(posedge clk);
            @(negedge clk);
            `CHK(clk_out[13:4], 10'h000)
            per(0, hi, lo);
            `CHK(hi, 4)
            @(posedge clk);
            sync <= 1'b0;
            @(negedge clk);
            wait_lvl(8, 1'b1, n);
            `CHK(clk_out[4], 1'b1)
            wait_lvl(12, 1'b1, n);
            `CHK(n, dl[i])
        end
        $display("test sync_delay done");
        // Clearing the half step while running must stretch the current group four level
        wait_lvl(12, 1'b1, n);
        wb(1'b1, REG_LARGE, 32'h0007_0003, q);
        wait_lvl(12, 1'b0, hi);
        `CHK(hi > 5, 1'b1)
        $display("test half_step done");
        @(posedge clk);
        ser_mode <= 1'b0;
        for (int h = 0; h < 2; h++) begin
            @(posedge clk);
            sel_high <= h[0];
            host.strap(1'b1, 1'b0, 1'b0);
            repeat (100) @(posedge clk);
            per(0, hi, lo);
            `CHK(hi, 2 * STRAP_HI)
            per(4, hi, lo);
            `CHK(hi, (h == 1) ? 2 * STRAP_HI : 2 * STRAP_LO)
            per(12, hi, lo);
            `CHK(hi, (h == 1) ? 2 * STRAP_G4_LO_H : 2 * STRAP_G4_LO_L)
            `CHK(out_type, TYPE_LVDS)
        end
        $display("test strap_mode done");
        give_verdict();
    end
endmodule
